//--- design/coe_exec.v
// Purpose: Executes return, halt, subtract, exclusive-OR and nibble-swap ops
// Assumes: APB slave on i_sys_clk; commands are written to the CMD register
// Notes: File ops read the file memory first, so they take one cycle more
`timescale 1ns/1ps
`include "coe_map.vh"

// Behaviour
// - Return pops return stack into program counter, two cycles, flags untouched.
// - Halt clears watchdog counter and its prescaler to zero.
// - Halt sets timeout status bit and clears powerdown status bit only.
// - After halt the core sleeps and executes no commands until a wake.
// - Literal subtract: literal minus accumulator into accumulator, updates C, DC, Z.
// - Literal XOR: accumulator XOR literal into accumulator, updates only Z.
// - File subtract: file register minus accumulator, updates C, DC, Z.
// - File XOR: accumulator XOR file register, updates only Z.
// - File op result goes to accumulator when dest is 0, file when 1.
// - Nibble swap exchanges file register nibbles, no flags changed.
module coe_exec (
  input wire i_sys_clk,
  input wire i_rstn,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire i_wake,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  output reg o_sleep
);

  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_FETCH = 5'h02;
  localparam [4:0] S_EXEC = 5'h04;
  localparam [4:0] S_RET2 = 5'h08;
  localparam [4:0] S_HALT = 5'h10;

  // Returns {carry, digit carry, result}; carries are inverted borrows
  function [9:0] coe_sub;
    input [7:0] a;
    input [7:0] b;
    reg [8:0] full;
    reg [4:0] low;
    begin
      full = {1'b0, a} - {1'b0, b};
      low = {1'b0, a[3:0]} - {1'b0, b[3:0]};
      coe_sub = {~full[8], ~low[4], full[7:0]};
    end
  endfunction

  function coe_zero;
    input [7:0] v;
    begin
      coe_zero = (v == 8'h00);
    end
  endfunction

  reg [4:0] state_r;
  reg [4:0] state_nxt;
  reg [2:0] op_r;
  reg dest_r;
  reg [`COE_FA_W-1:0] fa_r;
  reg [7:0] lit_r;
  reg [7:0] acc_r;
  reg c_r;
  reg dc_r;
  reg z_r;
  reg pd_r;
  reg to_r;
  reg [`COE_PC_W-1:0] pc_r;
  reg [`COE_PC_W-1:0] stk_r [0:`COE_STK_DEPTH-1];
  reg [`COE_SP_W-1:0] sp_r;
  reg [7:0] wdt_r;
  reg [7:0] pre_r;
  reg [`COE_FA_W-1:0] fsel_r;
  reg idle_q_r;
  integer k;

  wire [7:0] ram_rdata;
  wire in_idle = (state_r == S_IDLE);
  wire not_busy = in_idle || (state_r == S_HALT);
  wire is_file_op = (op_r == `COE_OP_SUBF) || (op_r == `COE_OP_XORF) ||
                    (op_r == `COE_OP_NIBBLE_SWAP_OP);
  wire [`COE_SP_W-1:0] sp_pop = sp_r - 1'b1;

  // APB: pready is raised one edge after setup, when the access is allowed
  wire hit_cmd = (i_paddr == `COE_ADDR_CMD);
  wire hit_acc = (i_paddr == `COE_ADDR_ACC);
  wire hit_stat = (i_paddr == `COE_ADDR_STAT);
  wire hit_pc = (i_paddr == `COE_ADDR_PC);
  wire hit_stk = (i_paddr == `COE_ADDR_STK);
  wire hit_wdt = (i_paddr == `COE_ADDR_WDT);
  wire hit_fa = (i_paddr == `COE_ADDR_FADDR);
  wire hit_fd = (i_paddr == `COE_ADDR_FDATA);
  wire mapped = hit_cmd | hit_acc | hit_stat | hit_pc | hit_stk | hit_wdt | hit_fa | hit_fd;
  // File data needs the memory pointed at fsel_r for a full cycle of idle
  wire acc_ok = hit_fd ? (in_idle && idle_q_r) : (i_pwrite ? not_busy : 1'b1);
  wire apb_rise = i_psel && !o_pready && acc_ok;
  wire apb_done = i_psel && i_penable && o_pready;
  wire wr_done = apb_done && i_pwrite && !o_pslverr;
  wire cmd_start = wr_done && hit_cmd && in_idle;

  reg [31:0] rd_val;
  always @* begin
    rd_val = 32'h0000_0000;
    case (1'b1)
      hit_cmd: rd_val = {13'h0000, op_r, dest_r, fa_r, lit_r};
      hit_acc: rd_val = {24'h00_0000, acc_r};
      hit_stat: rd_val = {25'h000_0000, (state_r == S_HALT), !not_busy, to_r, pd_r,
                          z_r, dc_r, c_r};
      hit_pc: rd_val = {19'h0_0000, pc_r};
      hit_stk: rd_val = {29'h0000_0000, sp_r};
      hit_wdt: rd_val = {16'h0000, pre_r, wdt_r};
      hit_fa: rd_val = {25'h000_0000, fsel_r};
      hit_fd: rd_val = {24'h00_0000, ram_rdata};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else if (apb_done) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else if (apb_rise) begin
      o_pready <= 1'b1;
      o_pslverr <= !mapped;
      o_prdata <= (mapped && !i_pwrite) ? rd_val : 32'h0000_0000;
    end
  end

  // Datapath for the op under execution
  wire [7:0] opnd = is_file_op ? ram_rdata : lit_r;
  wire [9:0] sub_v = coe_sub(opnd, acc_r);
  wire [7:0] xor_v = opnd ^ acc_r;
  wire [7:0] swap_v = {ram_rdata[3:0], ram_rdata[7:4]};

  reg [7:0] res;
  always @* begin
    case (op_r)
      `COE_OP_SUBL: res = sub_v[7:0];
      `COE_OP_SUBF: res = sub_v[7:0];
      `COE_OP_XORL: res = xor_v;
      `COE_OP_XORF: res = xor_v;
      `COE_OP_NIBBLE_SWAP_OP: res = swap_v;
      default: res = acc_r;
    endcase
  end

  wire in_exec = (state_r == S_EXEC);
  wire to_file = in_exec && is_file_op && (dest_r == `COE_DEST_FILE);
  wire to_acc = in_exec && !to_file && (op_r != `COE_OP_RET) && (op_r != `COE_OP_HALT) &&
                (op_r != `COE_OP_NONE);
  wire sw_fd_wr = wr_done && hit_fd && in_idle;
  wire ram_we = to_file || sw_fd_wr;
  wire [`COE_FA_W-1:0] ram_addr = in_idle ? fsel_r : fa_r;
  wire [7:0] ram_wdata = to_file ? res : i_pwdata[7:0];

  coe_file_ram u_ram (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_addr(ram_addr),
    .i_we(ram_we),
    .i_wdata(ram_wdata),
    .o_rdata(ram_rdata)
  );

  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (cmd_start) begin
          if (i_pwdata[`COE_CMD_OP_MSB] && (i_pwdata[`COE_CMD_OP_MSB:`COE_CMD_OP_LSB] !=
              `COE_OP_NONE)) begin
            state_nxt = S_FETCH;
          end else begin
            state_nxt = S_EXEC;
          end
        end
      end
      S_FETCH: state_nxt = S_EXEC;
      S_EXEC: begin
        if (op_r == `COE_OP_RET) begin
          state_nxt = S_RET2;
        end else if (op_r == `COE_OP_HALT) begin
          state_nxt = S_HALT;
        end else begin
          state_nxt = S_IDLE;
        end
      end
      S_RET2: state_nxt = S_IDLE;
      // only a wake leaves sleep; commands are dropped meanwhile
      S_HALT: state_nxt = i_wake ? S_IDLE : S_HALT;
      default: state_nxt = S_IDLE;
    endcase
  end

  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r <= S_IDLE;
      idle_q_r <= 1'b0;
      o_sleep <= 1'b0;
      op_r <= `COE_OP_RET;
      dest_r <= `COE_DEST_ACC;
      fa_r <= {`COE_FA_W{1'b0}};
      lit_r <= 8'h00;
      fsel_r <= {`COE_FA_W{1'b0}};
    end else begin
      state_r <= state_nxt;
      idle_q_r <= in_idle;
      o_sleep <= (state_nxt == S_HALT);
      if (cmd_start) begin
        op_r <= i_pwdata[`COE_CMD_OP_MSB:`COE_CMD_OP_LSB];
        dest_r <= i_pwdata[`COE_CMD_DEST_BIT];
        fa_r <= i_pwdata[`COE_CMD_FA_MSB:`COE_CMD_FA_LSB];
        lit_r <= i_pwdata[`COE_CMD_LIT_MSB:`COE_CMD_LIT_LSB];
      end
      if (wr_done && hit_fa) begin
        fsel_r <= i_pwdata[`COE_FA_W-1:0];
      end
    end
  end

  // Accumulator and arithmetic flags
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      acc_r <= `COE_ACC_RST;
      c_r <= 1'b0;
      dc_r <= 1'b0;
      z_r <= 1'b0;
    end else if (in_exec) begin
      if (to_acc) begin
        acc_r <= res;
      end
      if ((op_r == `COE_OP_SUBL) || (op_r == `COE_OP_SUBF)) begin
        c_r <= sub_v[9];
        dc_r <= sub_v[8];
      end
      if ((op_r == `COE_OP_SUBL) || (op_r == `COE_OP_SUBF) ||
          (op_r == `COE_OP_XORL) || (op_r == `COE_OP_XORF)) begin
        z_r <= coe_zero(res);
      end
    end else if (wr_done && not_busy) begin
      if (hit_acc) begin
        acc_r <= i_pwdata[7:0];
      end
      if (hit_stat) begin
        c_r <= i_pwdata[`COE_ST_C];
        dc_r <= i_pwdata[`COE_ST_DC];
        z_r <= i_pwdata[`COE_ST_Z];
      end
    end
  end

  // power status bits, only halt changes them
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pd_r <= `COE_PD_RST;
      to_r <= `COE_TO_RST;
    end else if (in_exec && (op_r == `COE_OP_HALT)) begin
      pd_r <= 1'b0;
      to_r <= 1'b1;
    end
  end

  // Watchdog keeps running in sleep, counting on i_sys_clk like the rest of the core
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wdt_r <= `COE_WDT_CLR;
      pre_r <= `COE_PRE_CLR;
    end else if (in_exec && (op_r == `COE_OP_HALT)) begin
      wdt_r <= `COE_WDT_CLR;
      pre_r <= `COE_PRE_CLR;
    end else begin
      pre_r <= pre_r + 8'h01;
      if (pre_r == `COE_PRE_LAST) begin
        wdt_r <= wdt_r + 8'h01;
      end
    end
  end

  // Return stack is circular: overflow overwrites the oldest entry
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pc_r <= `COE_PC_RST;
      sp_r <= `COE_SP_RST;
      for (k = 0; k < `COE_STK_DEPTH; k = k + 1) begin
        stk_r[k] <= `COE_PC_RST;
      end
    end else if (in_exec && (op_r == `COE_OP_RET)) begin
      pc_r <= stk_r[sp_pop];
      sp_r <= sp_pop;
    end else if (wr_done && not_busy) begin
      if (hit_pc) begin
        pc_r <= i_pwdata[`COE_PC_W-1:0];
      end
      if (hit_stk) begin
        stk_r[sp_r] <= i_pwdata[`COE_PC_W-1:0];
        sp_r <= sp_r + 1'b1;
      end
    end
  end

endmodule

//--- design/coe_map.vh
// Purpose: Register map, field layout, opcodes and reset values of the op executor
// Assumes: 32-bit APB data, one aligned word per register
// Notes: Byte addresses; bits above each field read as zero
`ifndef COE_MAP_VH
`define COE_MAP_VH

`define COE_ADDR_CMD 8'h00
`define COE_ADDR_ACC 8'h04
`define COE_ADDR_STAT 8'h08
`define COE_ADDR_PC 8'h0C
`define COE_ADDR_STK 8'h10
`define COE_ADDR_WDT 8'h14
`define COE_ADDR_FADDR 8'h18
`define COE_ADDR_FDATA 8'h1C

`define COE_CMD_LIT_MSB 7
`define COE_CMD_LIT_LSB 0
`define COE_CMD_FA_MSB 14
`define COE_CMD_FA_LSB 8
`define COE_CMD_DEST_BIT 15
`define COE_CMD_OP_MSB 18
`define COE_CMD_OP_LSB 16

`define COE_ST_C 0
`define COE_ST_DC 1
`define COE_ST_Z 2
`define COE_ST_PD 3
`define COE_ST_TO 4
`define COE_ST_BUSY 5
`define COE_ST_HALT 6

`define COE_OP_RET 3'h0
`define COE_OP_HALT 3'h1
`define COE_OP_SUBL 3'h2
`define COE_OP_XORL 3'h3
`define COE_OP_SUBF 3'h4
`define COE_OP_XORF 3'h5
`define COE_OP_NIBBLE_SWAP_OP 3'h6
`define COE_OP_NONE 3'h7

`define COE_PC_W 13
`define COE_STK_DEPTH 8
`define COE_SP_W 3
`define COE_FA_W 7
`define COE_ACC_RST 8'h00
`define COE_PC_RST 13'h0000
`define COE_SP_RST 3'h0
`define COE_WDT_CLR 8'h00
`define COE_PRE_CLR 8'h00
`define COE_PRE_LAST 8'hFF
`define COE_PD_RST 1'b1
`define COE_TO_RST 1'b1
`define COE_DEST_ACC 1'b0
`define COE_DEST_FILE 1'b1

`endif

//--- design/coe_file_ram.v
// Purpose: File register memory of the op executor, 128 bytes
// Assumes: One port; a read returns data one clock after the address
// Notes: Array has no reset; only the read data register is reset
`timescale 1ns/1ps
`include "coe_map.vh"

module coe_file_ram (
  input wire i_sys_clk,
  input wire i_rstn,
  input wire [`COE_FA_W-1:0] i_addr,
  input wire i_we,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata
);

  reg [7:0] mem_r [0:(1<<`COE_FA_W)-1];

  always @(posedge i_sys_clk) begin
    if (i_we) begin
      mem_r[i_addr] <= i_wdata;
    end
  end

  // Read-before-write: a same-cycle write shows up on the next read
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= mem_r[i_addr];
    end
  end

endmodule

//--- verification/coe_exec_properties.sv
// Purpose: Port-level checker for the op executor
// Assumes: Sees only the top ports; one clock domain
// Notes: Sleep entry is judged from the halt command seen on the bus
`timescale 1ns/1ps
`include "coe_map.vh"

module coe_exec_properties (
  input wire i_sys_clk,
  input wire i_rstn,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire i_wake,
  input wire [31:0] o_prdata,
  input wire o_pready,
  input wire o_pslverr,
  input wire o_sleep
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rstn);

  // A halt command taken while awake
  wire halt_w = i_psel && i_penable && o_pready && i_pwrite && !o_sleep &&
    i_paddr == `COE_ADDR_CMD && i_pwdata[18:16] == `COE_OP_HALT;
  // Beyond the last register or not word aligned
  wire unmapped_w = (i_paddr > `COE_ADDR_FDATA) || (i_paddr[1:0] != 2'b00);

  sequence s_halt_done;
    halt_w;
  endsequence
  sequence s_sleep_entry;
    ##[1:2] o_sleep;
  endsequence

  a_halt_sleeps: assert property (s_halt_done |-> s_sleep_entry)
    else $error("halt did not enter sleep");
  a_sleep_cause: assert property ($rose(o_sleep) |-> $past(halt_w) || $past(halt_w, 2))
    else $error("sleep entered without halt");
  a_sleep_holds: assert property (o_sleep && !i_wake |=> o_sleep)
    else $error("sleep left without wake");
  a_wake_exits: assert property (o_sleep && i_wake |=> !o_sleep)
    else $error("wake did not end sleep");
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  a_ready_access: assert property (o_pready |-> i_psel && i_penable)
    else $error("pready outside access phase");
  a_ready_bound: assert property (i_psel && i_penable |-> ##[0:12] o_pready)
    else $error("transfer not answered");
  a_err_unmapped: assert property (o_pready && unmapped_w |-> o_pslverr && o_prdata == 0)
    else $error("unmapped access not refused");
  a_err_ready: assert property (o_pslverr |-> o_pready && unmapped_w)
    else $error("pslverr on mapped access");
endmodule

bind coe_exec coe_exec_properties u_props (
  .i_sys_clk(i_sys_clk),
  .i_rstn(i_rstn),
  .i_psel(i_psel),
  .i_penable(i_penable),
  .i_pwrite(i_pwrite),
  .i_paddr(i_paddr),
  .i_pwdata(i_pwdata),
  .i_wake(i_wake),
  .o_prdata(o_prdata),
  .o_pready(o_pready),
  .o_pslverr(o_pslverr),
  .o_sleep(o_sleep)
);

//--- verification/cpu_op_exec_subset_bench.sv
// Purpose: Self-checking bench for the op executor over APB
// Assumes: Execution ends when the status busy bit is clear
// Notes: Halt runs last; wake brings the core back
`timescale 1ns/1ps
`include "coe_map.vh"

module cpu_op_exec_subset_bench;
  logic i_sys_clk = 0, i_rstn = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, i_wake = 0;
  logic [7:0] i_paddr = 0;
  logic [31:0] i_pwdata = 0;
  logic [31:0] rd;
  logic er;
  wire [31:0] o_prdata;
  wire o_pready, o_pslverr, o_sleep;
  integer n_fail = 0, num_checks = 0;

  coe_exec DUT (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .i_wake(i_wake),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .o_sleep(o_sleep)
  );

  always #5 i_sys_clk = ~i_sys_clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  // One idle cycle after each transfer so no signal is driven twice in a step
  // Waits for pready however long it takes; the watchdog ends a hang
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_sys_clk);
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_sys_clk);
  endtask

  task automatic op(input logic [2:0] c, input logic [7:0] k, input logic [6:0] fa,
                    input logic d);
    bus(1, `COE_ADDR_CMD, {13'h0, c, d, fa, k});
    do begin
      bus(0, `COE_ADDR_STAT, 0);
    end while (rd[`COE_ST_BUSY] !== 1'b0);
  endtask

  task automatic t_lit();
    logic [7:0] a [5] = '{8'h05, 8'h03, 8'h07, 8'h01, 8'hFF};
    logic [7:0] k [5] = '{8'h03, 8'h05, 8'h07, 8'h10, 8'h00};
    logic [7:0] r;
    for (int i = 0; i < 5; i++) begin
      bus(1, `COE_ADDR_ACC, a[i]);
      bus(1, `COE_ADDR_STAT, 0);
      op(`COE_OP_SUBL, k[i], 0, 0);
      r = k[i] - a[i];
      bus(0, `COE_ADDR_ACC, 0);
      chk(rd, r);
      bus(0, `COE_ADDR_STAT, 0);
      chk(rd[2:0], {r == 0, k[i][3:0] >= a[i][3:0], k[i] >= a[i]});
      bus(1, `COE_ADDR_ACC, a[i]);
      bus(1, `COE_ADDR_STAT, 3);
      op(`COE_OP_XORL, k[i], 0, 0);
      bus(0, `COE_ADDR_ACC, 0);
      chk(rd, a[i] ^ k[i]);
      bus(0, `COE_ADDR_STAT, 0);
      chk(rd[2:0], {a[i] == k[i], 2'b11});
    end
  endtask

  task automatic t_file();
    logic [6:0] fa [2] = '{7'h00, 7'h7F};
    logic [2:0] c;
    logic [7:0] v, r;
    logic [2:0] f;
    logic [7:0] w = 8'h3D;
    for (int i = 0; i < 6; i++) begin
      c = `COE_OP_SUBF + 3'(i / 2);
      v = 8'h3C + 8'(i);
      bus(1, `COE_ADDR_FADDR, fa[i[0]]);
      bus(1, `COE_ADDR_FDATA, v);
      bus(1, `COE_ADDR_ACC, w);
      bus(1, `COE_ADDR_STAT, 5);
      op(c, 0, fa[i[0]], i[0]);
      r = c == 4 ? v - w : c == 5 ? v ^ w : {v[3:0], v[7:4]};
      bus(0, `COE_ADDR_ACC, 0);
      chk(rd, i[0] ? w : r);
      bus(0, `COE_ADDR_FDATA, 0);
      chk(rd, i[0] ? r : v);
      bus(0, `COE_ADDR_STAT, 0);
      f = c == 6 ? 3'd5 : c == 5 ? {r == 0, 2'b01} : {r == 0, v[3:0] >= w[3:0], v >= w};
      chk(rd[2:0], f);
    end
  endtask

  task automatic t_ret();
    bus(1, `COE_ADDR_STK, 32'h0ABC);
    bus(1, `COE_ADDR_STK, 32'h1234);
    bus(1, `COE_ADDR_STAT, 6);
    op(`COE_OP_RET, 0, 0, 0);
    bus(0, `COE_ADDR_PC, 0);
    chk(rd, 32'h1234);
    op(`COE_OP_RET, 0, 0, 0);
    bus(0, `COE_ADDR_PC, 0);
    chk(rd, 32'h0ABC);
    bus(0, `COE_ADDR_STK, 0);
    chk(rd, 0);
    bus(0, `COE_ADDR_STAT, 0);
    chk(rd[2:0], 6);
    // The spare op code must leave everything as it was
    op(`COE_OP_NONE, 8'hFF, 7'h7F, 1'b1);
    bus(0, `COE_ADDR_STAT, 0);
    chk(rd[2:0], 6);
    bus(0, `COE_ADDR_PC, 0);
    chk(rd, 32'h0ABC);
  endtask

  task automatic t_err();
    bus(0, 8'h20, 0);
    chk(er, 1);
    chk(rd, 0);
    bus(1, 8'hFC, 32'hFFFF_FFFF);
    chk(er, 1);
    bus(0, 8'h06, 0);
    chk(er, 1);
    chk(rd, 0);
  endtask

  task automatic t_halt();
    bus(1, `COE_ADDR_STAT, 32'h7F);
    op(`COE_OP_HALT, 0, 0, 0);
    chk(o_sleep, 1);
    bus(0, `COE_ADDR_STAT, 0);
    chk(rd, 32'h57);
    bus(0, `COE_ADDR_WDT, 0);
    chk(rd[7:0], 0);
    chk(rd[15:13], 0);
    bus(1, `COE_ADDR_ACC, 32'hA5);
    op(`COE_OP_XORL, 8'hFF, 0, 0);
    bus(0, `COE_ADDR_ACC, 0);
    chk(rd, 32'hA5);
    i_wake <= 1'b1;
    @(posedge i_sys_clk);
    i_wake <= 1'b0;
    @(posedge i_sys_clk);
    chk(o_sleep, 0);
  endtask

  task automatic finish_test();
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    @(posedge i_sys_clk);
    t_lit();
    $display("literal ops done");
    t_file();
    $display("file ops done");
    t_ret();
    $display("return done");
    t_err();
    $display("unmapped done");
    t_halt();
    $display("halt done");
    finish_test();
  end

  // Whole run needs well under 10000 cycles
  initial begin
    #200us;
    n_fail++;
    finish_test();
  end
endmodule
